// File: inc/prr_pkg.sv
// Constants and types for the pattern register readout path.
// Assumes a single 50 MHz clock domain and one data beat per clock.
package prr_pkg;

    // =====================================================================
    // Mode register fields
    localparam logic [2:0] PRR_MR3_SEL      = 3'h3;
    localparam int         PRR_MR_W         = 18;
    localparam int         PRR_MR3_EN_BIT   = 2;
    localparam int         PRR_MR3_FMT_LSB  = 11;
    localparam int         PRR_MR3_PAGE_LSB = 0;
    localparam logic [1:0] PRR_BL_FIXED8    = 2'h0;
    localparam logic [1:0] PRR_BL_OTF       = 2'h1;
    localparam logic [1:0] PRR_BL_FIXED4    = 2'h2;

    // =====================================================================
    // Burst shape and latency
    localparam logic [2:0] PRR_BURST_LAST   = 3'h7;
    localparam logic [2:0] PRR_CHOP_HI_OFS  = 3'h4;
    localparam logic [5:0] PRR_MIN_RL       = 6'h02;

    // =====================================================================
    // Page zero power-up patterns, locations zero to three
    localparam logic [7:0] PRR_LOC0_RST     = 8'h55;
    localparam logic [7:0] PRR_LOC1_RST     = 8'h33;
    localparam logic [7:0] PRR_LOC2_RST     = 8'h0F;
    localparam logic [7:0] PRR_LOC3_RST     = 8'h00;

    // =====================================================================
    // Types
    typedef enum logic [1:0] {FMT_SERIAL, FMT_PARALLEL, FMT_STAGGER, FMT_RESERVED} prr_fmt_e;
    typedef enum logic {ST_IDLE, ST_DATA} prr_state_e;

    typedef struct packed {
        logic       vld;
        logic [1:0] loc;
        logic [1:0] page;
        prr_fmt_e   fmt;
        logic       bc4;
        logic       a2;
    } prr_req_s;

endpackage

// File: core/prr_core.sv
// Read path of the pattern readout registers: mode tracking, page zero
// storage, read latency pipeline and DQ/DQS burst formatting.
// Assumes the controller keeps its own command spacing and address rules;
// one DQ beat per clock, bursts at least eight clocks apart.

// Behaviour
// R1 - Readout bursts are fixed eight-beat or fixed four-beat chop only.
// R2 - Read inversion enable is ignored in readout mode; data never inverted.
// R3 - Chopped reads must start at column 000 or 100.
// R4 - Page zero starts at defaults; only page zero is writable, values persist.
// R5 - Page zero reads may use short spacing; pages one to three long.
// R6 - Before entry, controller locks DLL, precharges all and waits.
// R7 - Entry by register three write with bit 2 high, then delays.
// R8 - Register three bits 12:11 select serial, parallel, staggered or reserved.
// R9 - Register three bits 1:0 select page zero to three.
// R10 - Reads are redirected to location chosen by bank address bits 1:0.
// R11 - Chop bit selects burst; with on-the-fly setting controller drives it high.
// R12 - Column bit 2: eight-beat needs low; chop gives 0-3 or 4-7.
// R13 - Column bits 1:0 must be 00; other address bits ignored.
// R14 - Data bursts additive plus CAS latency after the read command.
// R15 - Exit by register three bit 2 low after exit delay.
// R16 - Serial format is required for status pages; patterns any format.
// R17 - Strobes toggle with data as in normal reads, honouring preamble.
// R18 - Serial: every lane carries the byte, bit 7 first, bit 0 last.
// R19 - Parallel: bit 7 on lane 0 to bit 0 on lane 7, every beat.
// R20 - Parallel format reads only location zero.
// R21 - Parallel: four lanes give upper nibble; sixteen lanes repeat the byte.
module prr_core
    import prr_pkg::*;
#(
    parameter int DQ_W    = 8,
    parameter int MAX_LAT = 64
)(
    input  wire logic                clock_i,
    input  wire logic                rstn_i,
    input  wire logic                mrs_i,
    input  wire logic [2:0]          mr_sel_i,
    input  wire logic [PRR_MR_W-1:0] mr_addr_i,
    input  wire logic [1:0]          mr0_bl_i,
    input  wire logic                rd_dbi_en_i,
    input  wire logic                rd_preamble_i,
    input  wire logic [4:0]          al_i,
    input  wire logic [4:0]          cl_i,
    input  wire logic                rd_i,
    input  wire logic [1:0]          ba_i,
    input  wire logic [2:0]          col_i,
    input  wire logic                burst_chop_address_bit_i,
    input  wire logic                pat_wr_i,
    input  wire logic [1:0]          pat_wr_loc_i,
    input  wire logic [7:0]          pat_wr_data_i,
    input  wire logic [95:0]         page_data_i,
    output logic      [DQ_W-1:0]     dq_o,
    output logic                     dq_oe_o,
    output logic                     dqs_o,
    output logic                     dqs_oe_o,
    output logic                     dbi_n_o,
    output logic                     mode_active_o,
    output logic      [1:0]          readout_format_o,
    output logic      [1:0]          page_o,
    output logic                     cmd_error_o
);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // =====================================================================
    // Mode register three tracking
    logic       mrs3;
    logic       rd_acc;
    logic       bc4;
    prr_fmt_e   fmt_q;
    logic [1:0] page_q;

    assign mrs3   = mrs_i && (mr_sel_i == PRR_MR3_SEL);
    assign rd_acc = rd_i && mode_active_o;

    // Enable, format and page captured on each register three write
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mode_active_o <= 1'b0;
            fmt_q         <= FMT_SERIAL;
            page_q        <= 2'h0;
        end
        else if (mrs3)
        begin
            mode_active_o <= mr_addr_i[PRR_MR3_EN_BIT];
            fmt_q         <= prr_fmt_e'(mr_addr_i[PRR_MR3_FMT_LSB +: 2]); // R8
            page_q        <= mr_addr_i[PRR_MR3_PAGE_LSB +: 2];            // R9
        end
    end

    assign readout_format_o = fmt_q;
    assign page_o           = page_q;

    // =====================================================================
    // Pattern storage: page zero writable, pages one to three from status
    logic [7:0] page0_q [4];
    logic [7:0] pat_all [16];

    // Page zero holds defaults until rewritten in readout mode
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            page0_q[0] <= PRR_LOC0_RST; // R4
            page0_q[1] <= PRR_LOC1_RST;
            page0_q[2] <= PRR_LOC2_RST;
            page0_q[3] <= PRR_LOC3_RST;
        end
        else if (pat_wr_i && mode_active_o && page_q == 2'h0)
        begin
            page0_q[pat_wr_loc_i] <= pat_wr_data_i; // R4
        end
    end

    // Flat view of all sixteen bytes, indexed by page and location
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            pat_all[i] = (i < 4) ? page0_q[i] : page_data_i[(i-4)*8 +: 8];
        end
    end

    // =====================================================================
    // Command decode and latency pipeline
    logic [5:0] rl;
    logic [5:0] rl_idx;
    prr_req_s   new_req;
    prr_req_s   line_q [MAX_LAT];

    // Fixed eight or fixed chop; on-the-fly uses the chop bit, high meaning eight
    assign bc4 = (mr0_bl_i == PRR_BL_FIXED4) ||
                 (mr0_bl_i == PRR_BL_OTF && !burst_chop_address_bit_i); // R1
    assign rl  = 6'(al_i) + 6'(cl_i); // R14
    assign rl_idx = (rl < PRR_MIN_RL) ? (PRR_MIN_RL - 6'h01) :
                    (int'(rl) > MAX_LAT) ? 6'(MAX_LAT - 1) :
                    (rl - 6'h01); // R14

    // Read redirected to the chosen location of the selected page
    always_comb
    begin
        new_req      = '0;
        new_req.vld  = rd_acc;
        new_req.loc  = ba_i;          // R10
        new_req.page = page_q;
        new_req.fmt  = fmt_q;
        new_req.bc4  = bc4;
        new_req.a2   = bc4 && col_i[2]; // R12
    end

    // Shift toward slot zero; a read enters so that data starts RL later
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < MAX_LAT; i++)
            begin
                line_q[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < MAX_LAT; i++)
            begin
                if (rd_acc && 6'(i) == rl_idx)
                begin
                    line_q[i] <= new_req; // R14
                end
                else
                begin
                    line_q[i] <= (i < MAX_LAT - 1) ? line_q[(i + 1) % MAX_LAT] : '0;
                end
            end
        end
    end

    // Flag reads that break the address rules, one cycle after the command
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cmd_error_o <= 1'b0;
        end
        else
        begin
            cmd_error_o <= (rd_acc && (col_i[1:0] != 2'h0 ||          // R13
                                       (!bc4 && col_i[2]) ||           // R12
                                       (fmt_q == FMT_PARALLEL && ba_i != 2'h0))) || // R20
                           (pat_wr_i && mode_active_o && page_q != 2'h0);
        end
    end

    // =====================================================================
    // Burst engine
    prr_state_e      state_q;
    prr_state_e      nxt_state;
    logic [2:0]      beat_q;
    logic [2:0]      nxt_beat;
    logic [2:0]      beat_ix;
    prr_req_s        req_q;
    prr_req_s        nxt_req;
    logic            lane_oe;
    logic [DQ_W-1:0] lane_d;

    // Launch from slot zero, then count eight beats
    always_comb
    begin
        nxt_state = state_q;
        nxt_beat  = beat_q;
        nxt_req   = req_q;
        if (line_q[0].vld)
        begin
            nxt_state = ST_DATA;
            nxt_beat  = 3'h0;
            nxt_req   = line_q[0];
        end
        else
        begin
            unique case (state_q)
                ST_IDLE: nxt_state = ST_IDLE;
                ST_DATA:
                begin
                    if (beat_q == PRR_BURST_LAST)
                        nxt_state = ST_IDLE;
                    else
                        nxt_beat = beat_q + 3'h1;
                end
            endcase
        end
    end

    // Chop from column bit 2 high starts at beat four; eight-beat ignores it
    assign beat_ix = nxt_req.a2 ? (nxt_beat + PRR_CHOP_HI_OFS) : nxt_beat; // R12
    // Chop drives four beats and tristates the rest
    assign lane_oe = (nxt_state == ST_DATA) && !(nxt_req.bc4 && nxt_beat[2]); // R1

    // Per-lane bit selection for each readout format
    for (genvar j = 0; j < DQ_W; j++)
    begin : g_lane
        localparam logic [2:0] PBIT = 3'(7 - (j % 8));
        localparam logic [1:0] SOFS = 2'(j % 4);
        always_comb
        begin
            unique case (nxt_req.fmt)
                FMT_PARALLEL: lane_d[j] = pat_all[{nxt_req.page, nxt_req.loc}][PBIT]; // R19 R21
                FMT_STAGGER:  lane_d[j] = pat_all[{nxt_req.page,
                                          2'(nxt_req.loc + SOFS)}][3'h7 - beat_ix];
                default:      lane_d[j] = pat_all[{nxt_req.page, nxt_req.loc}][3'h7 - beat_ix]; // R18
            endcase
        end
    end

    // Engine state
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= ST_IDLE;
            beat_q  <= 3'h0;
            req_q   <= '0;
        end
        else
        begin
            state_q <= nxt_state;
            beat_q  <= nxt_beat;
            req_q   <= nxt_req;
        end
    end

    // Registered pins; strobe preamble opens one or two cycles early
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            dq_o     <= '0;
            dq_oe_o  <= 1'b0;
            dqs_o    <= 1'b0;
            dqs_oe_o <= 1'b0;
            dbi_n_o  <= 1'b1;
        end
        else
        begin
            dq_o     <= lane_oe ? lane_d : '0;
            dq_oe_o  <= lane_oe;
            dqs_o    <= lane_oe && !nxt_beat[0];                          // R17
            dqs_oe_o <= lane_oe || line_q[1].vld ||
                        (rd_preamble_i && line_q[2].vld);                 // R17
            dbi_n_o  <= 1'b1;                                             // R2
        end
    end

    // =====================================================================
    // Checks
    sequence s_launch8;
        (state_q == ST_IDLE || beat_q == PRR_BURST_LAST) && line_q[0].vld && !line_q[0].bc4;
    endsequence
    sequence s_launch4;
        line_q[0].vld && line_q[0].bc4;
    endsequence

    a_full_burst: assert property (s_launch8 |=> dq_oe_o [*8]) // R1
        else $error("eight-beat burst not driven for eight cycles");
    a_chop_tristate: assert property (s_launch4 |=> dq_oe_o [*4] ##1 !dq_oe_o) // R1
        else $error("chopped burst did not tristate after four beats");
    a_no_invert: assert property (rd_dbi_en_i && dq_oe_o |-> dbi_n_o) // R2
        else $error("readout data marked inverted");
    a_mode_capture: assert property (mrs3 |=> mode_active_o == $past(mr_addr_i[PRR_MR3_EN_BIT]) &&
        readout_format_o == $past(mr_addr_i[PRR_MR3_FMT_LSB +: 2])) // R8
        else $error("register three format or enable not captured");
    a_page_capture: assert property (mrs3 |=> page_o == $past(mr_addr_i[1:0])) // R9
        else $error("page select not captured");
    a_page0_store: assert property (pat_wr_i && mode_active_o && page_q == 2'h0
        |=> page0_q[$past(pat_wr_loc_i)] == $past(pat_wr_data_i)) // R4
        else $error("page zero write lost");
    a_other_page_ro: assert property (page_q != 2'h0 |=> $stable(page0_q[0]) &&
        $stable(page0_q[1]) && $stable(page0_q[2]) && $stable(page0_q[3])) // R4
        else $error("page zero altered while another page selected");
    a_latency_slot: assert property (rd_acc && rl >= PRR_MIN_RL && int'(rl) <= MAX_LAT |=>
        line_q[$past(rl_idx)].vld && line_q[$past(rl_idx)].loc == $past(ba_i)) // R14 R10
        else $error("read not placed at its latency slot");
    a_launch_data: assert property (line_q[1].vld && !line_q[1].bc4 |=> ##1 dq_oe_o) // R14
        else $error("data did not start at read latency");
    a_serial_lanes: assert property (dq_oe_o && req_q.fmt == FMT_SERIAL |->
        dq_o == {DQ_W{dq_o[0]}}) // R18
        else $error("serial lanes differ");
    a_parallel_hold: assert property (dq_oe_o && $past(dq_oe_o) && beat_q != 3'h0 &&
        req_q.fmt == FMT_PARALLEL |-> $stable(dq_o)) // R19
        else $error("parallel pattern changed within burst");
    a_strobe_toggle: assert property (dq_oe_o && $past(dq_oe_o) |->
        dqs_oe_o && dqs_o != $past(dqs_o)) // R17
        else $error("strobe did not toggle with data");
    a_preamble: assert property (line_q[0].vld && state_q == ST_IDLE |-> dqs_oe_o && !dqs_o) // R17
        else $error("strobe preamble missing");

    if (DQ_W == 16)
    begin : g_x16_chk
        a_byte_repeat: assert property (dq_oe_o && req_q.fmt == FMT_PARALLEL |->
            dq_o[15:8] == dq_o[7:0]) // R21
            else $error("upper byte differs from lower in parallel format");
    end

endmodule

// File: verif/prr_ctrl_model.sv
// Memory controller model driving the command side of the readout path.
// Assumes the bench calls its tasks and owns latency and preamble levels.
module prr_ctrl_model
    import prr_pkg::*;
#(
    parameter int MOD_GAP = 4
)(
    input  wire logic                clock_i,
    output logic                     mrs_o,
    output logic      [2:0]          mr_sel_o,
    output logic      [PRR_MR_W-1:0] mr_addr_o,
    output logic                     rd_o,
    output logic      [1:0]          ba_o,
    output logic      [2:0]          col_o,
    output logic                     bc_o,
    output logic                     pat_wr_o,
    output logic      [1:0]          pat_wr_loc_o,
    output logic      [7:0]          pat_wr_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Idle levels at time zero
    initial
    begin
        mrs_o = 1'h0;
        mr_sel_o = 3'h4;
        mr_addr_o = '0;
        rd_o = 1'h0;
        ba_o = 2'h0;
        col_o = 3'h0;
        bc_o = 1'h0;
        pat_wr_o = 1'h0;
        pat_wr_loc_o = 2'h0;
        pat_wr_data_o = 8'h00;
    end

    // =====================================================================
    // Register three write, then settle gap before the next command
    // Banks taken as precharged and the lock done before any entry
    task automatic mrs(input logic [PRR_MR_W-1:0] addr);
        @(posedge clock_i);
        mrs_o <= 1'h1;
        mr_sel_o <= PRR_MR3_SEL;
        mr_addr_o <= addr;
        @(posedge clock_i);
        mrs_o <= 1'h0;
        mr_sel_o <= 3'h4;
        mr_addr_o <= ~addr;
        repeat (MOD_GAP) @(posedge clock_i);
    endtask

    // =====================================================================
    // Read command; returns at the command edge; address lines scrambled after
    // Column bits 1:0 always 00, chop column 000 or 100 only
    task automatic rd(input logic [1:0] loc, input logic [2:0] col, input logic bc);
        @(posedge clock_i);
        rd_o <= 1'h1;
        ba_o <= loc;
        col_o <= col;
        bc_o <= bc;
        @(posedge clock_i);
        rd_o <= 1'h0;
        ba_o <= ~loc;
        col_o <= ~col;
        bc_o <= ~bc;
    endtask

    // =====================================================================
    // Page zero pattern write, one byte
    task automatic pat(input logic [1:0] loc, input logic [7:0] data);
        @(posedge clock_i);
        pat_wr_o <= 1'h1;
        pat_wr_loc_o <= loc;
        pat_wr_data_o <= data;
        @(posedge clock_i);
        pat_wr_o <= 1'h0;
        pat_wr_data_o <= ~data;
    endtask
endmodule

// File: verif/pattern_register_readout_tb_top.sv
// Self-checking bench for the pattern readout path, eight and sixteen lanes, RL of 3.
// Assumes the controller model sequences commands; one beat per clock.
module pattern_register_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import prr_pkg::*;

    logic        clock_i = 1'h0;
    logic        rstn_i = 1'h0;
    logic [1:0]  mr0_bl = PRR_BL_FIXED8;
    logic [95:0] page_data = 96'hA1B2_C3D4_E5F6_0718_293A_4B5C;
    logic        mrs, rd, bc, pat_wr, dq_oe_o, dqs_o, dqs_oe_o, dbi_n_o;
    logic        mode_active_o, cmd_error_o;
    logic [2:0]  mr_sel, col;
    logic [1:0]  ba, pat_loc, readout_format_o, page_o;
    logic [7:0]  pat_data, dq_o;
    logic [PRR_MR_W-1:0] mr_addr;
    logic        rd_pre = 1'h0;
    logic [15:0] dq_wide;
    int          err_total = 0;
    int          n_checks = 0;

    // =====================================================================
    // Clock, partner and design
    initial
    begin
        forever #10 clock_i = ~clock_i;
    end

    prr_ctrl_model ctl (.clock_i(clock_i), .mrs_o(mrs), .mr_sel_o(mr_sel),
        .mr_addr_o(mr_addr), .rd_o(rd), .ba_o(ba), .col_o(col), .bc_o(bc),
        .pat_wr_o(pat_wr), .pat_wr_loc_o(pat_loc), .pat_wr_data_o(pat_data));

    prr_core #(.DQ_W(8)) DUT (.clock_i(clock_i), .rstn_i(rstn_i), .mrs_i(mrs),
        .mr_sel_i(mr_sel), .mr_addr_i(mr_addr), .mr0_bl_i(mr0_bl), .rd_dbi_en_i(1'h1),
        .rd_preamble_i(rd_pre), .al_i(5'h01), .cl_i(5'h02), .rd_i(rd), .ba_i(ba),
        .col_i(col), .burst_chop_address_bit_i(bc), .pat_wr_i(pat_wr),
        .pat_wr_loc_i(pat_loc), .pat_wr_data_i(pat_data), .page_data_i(page_data),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o),
        .dbi_n_o(dbi_n_o), .mode_active_o(mode_active_o),
        .readout_format_o(readout_format_o), .page_o(page_o), .cmd_error_o(cmd_error_o));

    // Sixteen-lane copy on the same commands, for the byte repeat
    prr_core #(.DQ_W(16)) DUT_WIDE (.clock_i(clock_i), .rstn_i(rstn_i), .mrs_i(mrs),
        .mr_sel_i(mr_sel), .mr_addr_i(mr_addr), .mr0_bl_i(mr0_bl), .rd_dbi_en_i(1'h1),
        .rd_preamble_i(rd_pre), .al_i(5'h01), .cl_i(5'h02), .rd_i(rd), .ba_i(ba),
        .col_i(col), .burst_chop_address_bit_i(bc), .pat_wr_i(pat_wr),
        .pat_wr_loc_i(pat_loc), .pat_wr_data_i(pat_data), .page_data_i(page_data),
        .dq_o(dq_wide), .dq_oe_o(), .dqs_o(), .dqs_oe_o(), .dbi_n_o(), .mode_active_o(),
        .readout_format_o(), .page_o(), .cmd_error_o());

    // =====================================================================
    // Compare and verdict helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask

    task automatic end_of_test;
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Enter readout mode with a format and page
    task automatic enter(input logic [1:0] fmt, input logic [1:0] pg);
        ctl.mrs({5'h00, fmt, 8'h00, 1'h1, pg});
        chk({mode_active_o, readout_format_o, page_o}, {3'h1, fmt, pg}, "entry");
    endtask

    // One read: strobe preamble, beats, lanes, then release of the bus
    task automatic burst(input logic [1:0] loc, input logic [2:0] c, input logic b,
                         input logic [7:0] v, input logic par, input int beats);
        logic [7:0] e;
        int         o;
        o = c[2] ? 4 : 0;
        ctl.rd(loc, c, b);
        #1;
        chk({7'h00, cmd_error_o}, 8'h00, "address rules");
        @(posedge clock_i);
        #1;
        chk({7'h00, dqs_oe_o}, {7'h00, rd_pre}, "long preamble");
        @(posedge clock_i);
        #1;
        chk({dqs_oe_o, dq_oe_o, dqs_o}, 8'h04, "preamble");
        for (int k = 0; k < beats; k++)
        begin
            @(posedge clock_i);
            #1;
            for (int j = 0; j < 8; j++)
                e[j] = par ? v[7-j] : v[7-k-o];
            chk({dq_oe_o, dqs_o, dbi_n_o}, {5'h00, 1'h1, ~k[0], 1'h1}, "beat");
            chk(dq_o, e, "data");
            chk(dq_wide[15:8], e, "upper byte");
            chk(dq_wide[7:0], e, "lower byte");
        end
        @(posedge clock_i);
        #1;
        chk({dq_oe_o, dqs_oe_o}, 8'h00, "burst end");
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_serial;
        enter(2'h0, 2'h0);
        burst(2'h0, 3'h0, 1'h0, PRR_LOC0_RST, 1'h0, 8);
        burst(2'h1, 3'h0, 1'h0, PRR_LOC1_RST, 1'h0, 8);
        burst(2'h2, 3'h0, 1'h0, PRR_LOC2_RST, 1'h0, 8);
        burst(2'h3, 3'h0, 1'h0, PRR_LOC3_RST, 1'h0, 8);
    endtask

    task automatic t_chop;
        mr0_bl <= PRR_BL_FIXED4;
        burst(2'h1, 3'h4, 1'h0, PRR_LOC1_RST, 1'h0, 4);
        burst(2'h2, 3'h0, 1'h0, PRR_LOC2_RST, 1'h0, 4);
        mr0_bl <= PRR_BL_OTF;
        burst(2'h0, 3'h0, 1'h1, PRR_LOC0_RST, 1'h0, 8);
        mr0_bl <= PRR_BL_FIXED8;
    endtask

    task automatic t_write_parallel;
        ctl.pat(2'h0, 8'h7F);
        burst(2'h0, 3'h0, 1'h0, 8'h7F, 1'h0, 8);
        enter(2'h1, 2'h0);
        burst(2'h0, 3'h0, 1'h0, 8'h7F, 1'h1, 8);
    endtask

    task automatic t_pages;
        logic [7:0] sp [4];
        logic [7:0] e;
        sp = '{8'h7F, PRR_LOC1_RST, PRR_LOC2_RST, PRR_LOC3_RST};
        rd_pre <= 1'h1;
        enter(2'h0, 2'h1);
        ctl.pat(2'h0, 8'h00);
        #1;
        chk({7'h00, cmd_error_o}, 8'h01, "refused write");
        burst(2'h2, 3'h0, 1'h0, page_data[23:16], 1'h0, 8);
        enter(2'h0, 2'h2);
        burst(2'h1, 3'h0, 1'h0, page_data[47:40], 1'h0, 8);
        enter(2'h3, 2'h0);
        burst(2'h1, 3'h0, 1'h0, PRR_LOC1_RST, 1'h0, 8);
        enter(2'h2, 2'h0);
        ctl.rd(2'h0, 3'h0, 1'h0);
        repeat (2) @(posedge clock_i);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clock_i);
            #1;
            for (int j = 0; j < 8; j++)
                e[j] = sp[j % 4][7 - k];
            chk(dq_o, e, "staggered lanes");
        end
        rd_pre <= 1'h0;
        enter(2'h0, 2'h0);
        burst(2'h0, 3'h0, 1'h0, 8'h7F, 1'h0, 8);
    endtask

    task automatic t_exit;
        ctl.mrs({PRR_MR_W{1'h0}});
        chk({7'h00, mode_active_o}, 8'h00, "exit");
        ctl.rd(2'h0, 3'h0, 1'h0);
        repeat (6)
        begin
            @(posedge clock_i);
            #1;
            chk({dq_oe_o, dqs_oe_o}, 8'h00, "read outside mode");
        end
    endtask

    // =====================================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (16) @(posedge clock_i);
        rstn_i <= 1'h1;
        #1;
        chk({mode_active_o, dq_oe_o, dbi_n_o, cmd_error_o}, 8'h02, "reset");
        t_serial();
        t_chop();
        t_write_parallel();
        t_pages();
        t_exit();
        end_of_test();
    end

    initial
    begin
        #100us;
        err_total++;
        end_of_test();
    end
endmodule
